/* File: logic/program_buffer_nv_store.sv */
`timescale 1ns/100ps
module program_buffer_nv_store #(
    parameter int DEPTH = nv_store_pkg::BUF_WORDS,
    parameter logic [14:0] FACTORY_START = nv_store_pkg::FACTORY_BASE,
    parameter int WRITE_CYCLES = nv_store_pkg::WRITE_CYC,
    parameter int SETUP_CYCLES = nv_store_pkg::SETUP_CYC,
    parameter int WORD_CYCLES = nv_store_pkg::WORD_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command channel
    input wire logic cmd_valid,
    input wire nv_store_pkg::cmd_req_t cmd,
    output logic cmd_ready,
    output logic done_pulse,
    output nv_store_pkg::cmd_resp_t resp,
    // Download words from the serial side
    input wire logic dl_valid,
    input wire nv_store_pkg::dl_word_t dl,
    // Executor read port
    input wire logic [9:0] exec_addr,
    output logic [15:0] exec_data,
    output logic [9:0] prog_len,
    // Data register file port
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_idx,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // EEPROM word port
    output logic nv_rd,
    output logic nv_wr,
    output logic [14:0] nv_addr,
    output logic [15:0] nv_wdata,
    input wire logic [15:0] nv_rdata,
    // Status
    output logic busy,
    output logic download_mode,
    output logic nv_fault
);
    typedef enum {
        ST_IDLE, ST_WHDR, ST_WNULL, ST_WBODY, ST_WAIT, ST_RSETUP, ST_RHDR, ST_RSKIP,
        ST_RBODY, ST_CHECK
    } state_t;

    state_t st_r;
    logic [15:0] mem [DEPTH];
    logic [9:0] len_r, cnt_r, total_r;
    logic [14:0] addr_r;
    logic [5:0] csum_r, want_r;
    logic [7:0] ridx_r;
    logic half_r, is_reg_r, run_r, t2_r, refused_r, dl_r, fault_r, done_r, hdr_r;
    logic [15:0] lo_r, exec_r;
    nv_store_pkg::cmd_req_t req_r;
    logic tstart;
    logic [19:0] tcycles;
    logic tdone;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic is_multi(input nv_store_pkg::cmd_t c);
        return c == nv_store_pkg::multi_register_save_cmd ||
               c == nv_store_pkg::multi_register_recall_cmd;
    endfunction

    function automatic logic reg_ok(input nv_store_pkg::cmd_req_t c);
        logic [8:0] last;
        last = 9'(c.reg_idx) + 9'(c.reg_cnt) - 9'd1;
        return c.reg_idx >= nv_store_pkg::USER_REG_LO && c.reg_cnt != 4'h0 &&
               c.reg_cnt <= 4'(nv_store_pkg::MULTI_REG_MAX) &&
               last <= 9'(nv_store_pkg::USER_REG_HI);
    endfunction

    wire idle = st_r == ST_IDLE;
    wire take = cmd_valid && idle && !fault_r;
    wire multi_bad = is_multi(cmd.op) && !reg_ok(cmd);
    wire nv_bad = cmd.nv_addr >= FACTORY_START;
    wire [9:0] words_nxt = is_reg_r ? 10'({req_r.reg_cnt, 1'b0}) : len_r;
    // Extra overhead word for long programs
    wire long_prog = !is_reg_r && len_r > 10'(nv_store_pkg::LONG_PROG_WORDS);
    wire page_end = addr_r[4:0] == 5'h1F;
    // Header carries the stored word count, not the buffer length
    wire [15:0] hdr_word = {csum_r, total_r};
    wire [15:0] body_word = is_reg_r ? (half_r ? reg_rdata[31:16] : reg_rdata[15:0])
                                     : mem[cnt_r];
    wire [5:0] body_sum = csum_r + body_word[5:0] + body_word[11:6] + 6'(body_word[15:12]);
    // Checksum pass keeps the EEPROM port quiet
    wire writing = st_r == ST_WHDR || st_r == ST_WNULL || (st_r == ST_WBODY && hdr_r);
    wire last_word = (st_r == ST_WBODY && cnt_r + 10'd1 == total_r) ||
                     (st_r == ST_WNULL && total_r == 10'd0);

    assign cmd_ready = idle && !fault_r;
    assign busy = !idle;
    assign download_mode = dl_r;
    assign nv_fault = fault_r;
    assign done_pulse = done_r;
    assign resp = '{refused: refused_r, nv_error: fault_r, run_t1: run_r && !t2_r,
                    run_t2: run_r && t2_r};
    assign exec_data = exec_r;
    assign prog_len = len_r;
    assign nv_rd = st_r == ST_RHDR || st_r == ST_RSKIP || st_r == ST_RBODY;
    assign nv_wr = writing;
    assign nv_addr = addr_r;
    assign nv_wdata = st_r == ST_WHDR ? hdr_word : (st_r == ST_WNULL ? nv_store_pkg::NULL_WORD
                                                                      : body_word);
    assign reg_idx = ridx_r;
    assign reg_rd = st_r == ST_WBODY && is_reg_r;
    assign reg_wr = st_r == ST_RBODY && is_reg_r && half_r && tdone;
    assign reg_wdata = {nv_rdata, lo_r};
    assign tstart = (writing && (page_end || last_word)) || (take && !multi_bad && !nv_bad &&
                    (cmd.op inside {nv_store_pkg::load_buffer_cmd,
                    nv_store_pkg::load_and_execute_cmd, nv_store_pkg::second_thread_launch_cmd,
                    nv_store_pkg::first_thread_forced_load_cmd,
                    nv_store_pkg::single_register_recall_cmd,
                    nv_store_pkg::multi_register_recall_cmd})) ||
                    ((st_r == ST_RSETUP || nv_rd) && tdone && st_r != ST_CHECK &&
                     !(st_r == ST_RBODY && cnt_r + 10'd1 >= total_r));
    assign tcycles = writing ? 20'(WRITE_CYCLES) :
                     (idle ? 20'(SETUP_CYCLES) : 20'(WORD_CYCLES));

    nv_page_timer #(.WIDTH(20)) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(tstart),
        .cycles(tcycles),
        .done(tdone)
    );

    // ------------------------------------------------------------
    // Buffer memory, no reset: volatile contents
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        exec_r <= mem[exec_addr];
        if (dl_r && dl_valid) begin
            mem[dl.addr] <= dl.data;
        end else if (st_r == ST_RBODY && !is_reg_r && tdone) begin
            mem[cnt_r] <= nv_rdata;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            len_r <= '0;
            cnt_r <= '0;
            total_r <= '0;
            addr_r <= '0;
            csum_r <= '0;
            want_r <= '0;
            ridx_r <= '0;
            half_r <= 1'b0;
            is_reg_r <= 1'b0;
            run_r <= 1'b0;
            t2_r <= 1'b0;
            refused_r <= 1'b0;
            dl_r <= 1'b0;
            fault_r <= 1'b0;
            done_r <= 1'b0;
            hdr_r <= 1'b0;
            lo_r <= '0;
            req_r <= '0;
        end else begin
            done_r <= 1'b0;
            run_r <= 1'b0;
            if (dl_r && dl_valid && dl.addr >= len_r && 32'(dl.addr) < DEPTH) begin
                len_r <= dl.addr + 10'd1;
            end
            case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        req_r <= cmd;
                        addr_r <= cmd.nv_addr;
                        ridx_r <= cmd.reg_idx;
                        t2_r <= cmd.op == nv_store_pkg::second_thread_launch_cmd;
                        is_reg_r <= cmd.op >= nv_store_pkg::single_register_save_cmd;
                        refused_r <= multi_bad || nv_bad;
                        cnt_r <= '0;
                        half_r <= 1'b0;
                        csum_r <= '0;
                        if (multi_bad || nv_bad) begin
                            done_r <= 1'b1;
                        end else begin
                            case (cmd.op)
                                nv_store_pkg::clear_buffer_cmd: begin
                                    len_r <= '0;
                                    dl_r <= 1'b0;
                                    done_r <= 1'b1;
                                end
                                nv_store_pkg::enter_download_cmd: begin
                                    len_r <= '0;
                                    dl_r <= 1'b1;
                                    done_r <= 1'b1;
                                end
                                nv_store_pkg::run_buffer_cmd: begin
                                    dl_r <= 1'b0;
                                    run_r <= 1'b1;
                                    done_r <= 1'b1;
                                end
                                nv_store_pkg::store_buffer_cmd,
                                nv_store_pkg::single_register_save_cmd,
                                nv_store_pkg::multi_register_save_cmd: begin
                                    dl_r <= 1'b0;
                                    st_r <= ST_WBODY; // Sum body first, then write header, null word, body
                                    hdr_r <= 1'b0;
                                end
                                default: begin
                                    dl_r <= 1'b0;
                                    st_r <= ST_RSETUP;
                                end
                            endcase
                        end
                    end
                end
                ST_WBODY: begin
                    if (!hdr_r) begin
                        // Checksum pass, no NV traffic
                        if (cnt_r >= words_nxt) begin
                            total_r <= words_nxt;
                            cnt_r <= '0;
                            hdr_r <= 1'b1;
                            half_r <= 1'b0;
                            ridx_r <= req_r.reg_idx;
                            st_r <= ST_WHDR;
                        end else begin
                            csum_r <= body_sum;
                            cnt_r <= cnt_r + 10'd1;
                            half_r <= !half_r;
                            if (is_reg_r && half_r) ridx_r <= ridx_r + 8'd1;
                        end
                    end else begin
                        addr_r <= addr_r + 15'd1;
                        cnt_r <= cnt_r + 10'd1;
                        half_r <= !half_r;
                        if (is_reg_r && half_r) ridx_r <= ridx_r + 8'd1;
                        if (tstart) st_r <= ST_WAIT;
                    end
                end
                ST_WHDR: begin
                    addr_r <= addr_r + (long_prog ? 15'd2 : 15'd1);
                    st_r <= tstart ? ST_WAIT : ST_WNULL;
                end
                ST_WNULL: begin
                    addr_r <= addr_r + 15'd1;
                    st_r <= tstart ? ST_WAIT : ST_WBODY;
                end
                ST_WAIT: begin
                    if (tdone) begin
                        if (cnt_r >= total_r && hdr_r && addr_r != req_r.nv_addr + 15'd1) begin
                            st_r <= ST_IDLE;
                            done_r <= 1'b1;
                        end else if (addr_r == req_r.nv_addr + 15'd1 ||
                                     (long_prog && addr_r == req_r.nv_addr + 15'd2)) begin
                            st_r <= ST_WNULL;
                        end else begin
                            st_r <= ST_WBODY;
                        end
                    end
                end
                ST_RSETUP: if (tdone) st_r <= ST_RHDR;
                ST_RHDR: begin
                    if (tdone) begin
                        want_r <= nv_rdata[15:10];
                        total_r <= nv_rdata[9:0];
                        addr_r <= addr_r + ((!is_reg_r &&
                                  nv_rdata[9:0] > 10'(nv_store_pkg::LONG_PROG_WORDS)) ?
                                  15'd2 : 15'd1);
                        st_r <= ST_RSKIP;
                    end
                end
                ST_RSKIP: begin
                    if (tdone) begin
                        addr_r <= addr_r + 15'd1;
                        st_r <= total_r == 10'd0 ? ST_CHECK : ST_RBODY;
                    end
                end
                ST_RBODY: begin
                    if (tdone) begin
                        csum_r <= csum_r + nv_rdata[5:0] + nv_rdata[11:6] + 6'(nv_rdata[15:12]);
                        lo_r <= nv_rdata;
                        half_r <= !half_r;
                        if (is_reg_r && half_r) ridx_r <= ridx_r + 8'd1;
                        addr_r <= addr_r + 15'd1;
                        cnt_r <= cnt_r + 10'd1;
                        if (cnt_r + 10'd1 >= total_r) st_r <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    st_r <= ST_IDLE;
                    done_r <= 1'b1;
                    if (csum_r != want_r) begin
                        fault_r <= 1'b1;
                    end else begin
                        if (!is_reg_r) len_r <= total_r;
                        run_r <= req_r.op inside {nv_store_pkg::load_and_execute_cmd,
                            nv_store_pkg::second_thread_launch_cmd,
                            nv_store_pkg::first_thread_forced_load_cmd};
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    fault_halts_a: assert property (@(posedge ref_clk) disable iff (rst)
        fault_r |-> !cmd_ready && !resp.run_t1) else $error("command taken after fault");
    bad_multi_a: assert property (@(posedge ref_clk) disable iff (rst)
        take && multi_bad |=> refused_r && done_pulse && !busy) else $error("multi not refused");
    null_word_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_r == ST_WNULL |-> nv_wr && nv_wdata == 16'h0000) else $error("null word missing");
    header_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_r == ST_WHDR |-> nv_addr == req_r.nv_addr && nv_wdata[9:0] == total_r)
        else $error("header misplaced");
    busy_span_a: assert property (@(posedge ref_clk) disable iff (rst)
        take && !multi_bad && !nv_bad && cmd.op == nv_store_pkg::store_buffer_cmd |=>
        busy) else $error("store not busy");
    page_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        writing && page_end |=> st_r == ST_WAIT) else $error("page write skipped");
    factory_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
        take && nv_bad |=> refused_r && !busy) else $error("factory access allowed");
    clear_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        take && !nv_bad && cmd.op == nv_store_pkg::clear_buffer_cmd |=> prog_len == 10'd0)
        else $error("clear failed");
    cov_store_c: cover property (@(posedge ref_clk) st_r == ST_WAIT ##1 st_r == ST_IDLE);
    cov_load_c: cover property (@(posedge ref_clk) st_r == ST_CHECK && csum_r == want_r);
    cov_fault_c: cover property (@(posedge ref_clk) $rose(fault_r));
endmodule

/* File: logic/nv_store_pkg.sv */
package nv_store_pkg;

    // ------------------------------------------------------------
    // Sizes and memory map
    // ------------------------------------------------------------
    localparam int BUF_WORDS = 1023;
    localparam int BUF_WORDS_OLD = 200;
    localparam int BUF_AW = 10;
    localparam int NV_AW = 15;
    localparam logic [14:0] INIT_PROG_BASE = 15'h0000;
    localparam logic [14:0] USER_PROG_BASE = 15'h0200;
    localparam logic [14:0] FACTORY_BASE = 15'h7F00;
    localparam logic [14:0] FACTORY_BASE_ALT = 15'h7800;
    localparam logic [15:0] NULL_WORD = 16'h0000;
    localparam int PAGE_WORDS = 32;
    localparam int PAGE_BITS = 5;
    localparam int LONG_PROG_WORDS = 254;
    localparam logic [7:0] USER_REG_LO = 8'h0A;
    localparam logic [7:0] USER_REG_HI = 8'hC7;
    localparam int MULTI_REG_MAX = 10;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int WRITE_TIME_US = 10_000;
    localparam int READ_SETUP_US = 500;
    localparam int READ_WORD_US = 120;
    localparam int WRITE_CYC = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SETUP_CYC = READ_SETUP_US * (CLK_HZ / 1_000_000);
    localparam int WORD_CYC = READ_WORD_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // Commands and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        clear_buffer_cmd,
        enter_download_cmd,
        store_buffer_cmd,
        run_buffer_cmd,
        load_buffer_cmd,
        load_and_execute_cmd,
        second_thread_launch_cmd,
        first_thread_forced_load_cmd,
        single_register_save_cmd,
        multi_register_save_cmd,
        single_register_recall_cmd,
        multi_register_recall_cmd
    } cmd_t;

    typedef struct packed {
        cmd_t op;
        logic [14:0] nv_addr;
        logic [7:0] reg_idx;
        logic [3:0] reg_cnt;
        logic thread2;
    } cmd_req_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] data;
    } dl_word_t;

    typedef struct packed {
        logic refused;
        logic nv_error;
        logic run_t1;
        logic run_t2;
    } cmd_resp_t;

endpackage

/* File: logic/nv_page_timer.sv */
`timescale 1ns/100ps
module nv_page_timer #(
    parameter int WIDTH = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [WIDTH-1:0] cycles,
    output logic done
);
    logic [WIDTH-1:0] cnt_r;
    logic run_r;

    assign done = run_r && (cnt_r == '0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (start) begin
            cnt_r <= cycles - WIDTH'(1);
            run_r <= 1'b1;
        end else if (done) begin
            run_r <= 1'b0;
        end else if (run_r) begin
            cnt_r <= cnt_r - WIDTH'(1);
        end
    end
endmodule

/* File: dv/nv_partner.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Paged EEPROM and data register file seen from the block
// ------------------------------------------------------------
module nv_partner (
    // Clock
    input wire logic ref_clk,
    // EEPROM word port
    input wire logic nv_rd,
    input wire logic nv_wr,
    input wire logic [14:0] nv_addr,
    input wire logic [15:0] nv_wdata,
    output logic [15:0] nv_rdata,
    // Register file port
    input wire logic reg_wr,
    input wire logic [7:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata
);
    logic [15:0] mem [0:32767];
    logic [31:0] regs [0:255];
    logic [15:0] last_r;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        foreach (regs[i]) regs[i] = 32'h0000_0000;
        last_r = 16'h0000;
    end
    // Released bus shows the inverse of the last word, so stale data never matches
    assign nv_rdata = nv_rd ? mem[nv_addr] : ~last_r;
    assign reg_rdata = regs[reg_idx];
    always @(posedge ref_clk) begin
        if (nv_rd) last_r <= mem[nv_addr];
        if (nv_wr) mem[nv_addr] <= nv_wdata;
        if (reg_wr) regs[reg_idx] <= reg_wdata;
    end
endmodule

/* File: dv/program_buffer_nv_store_bench.sv */
`timescale 1ns/100ps
module program_buffer_nv_store_bench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    // Short wait counts keep the run small
    localparam int T = 4;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic dl_valid = 1'b0;
    nv_store_pkg::cmd_req_t cmd = '0;
    nv_store_pkg::dl_word_t dl = '0;
    nv_store_pkg::cmd_resp_t resp;
    logic [9:0] exec_addr = 10'h000;
    logic [9:0] prog_len;
    logic [15:0] exec_data, nv_wdata, nv_rdata;
    logic cmd_ready, done_pulse, reg_rd, reg_wr, nv_rd, nv_wr, busy, download_mode, nv_fault;
    logic seen1, seen2;
    logic [7:0] reg_idx;
    logic [31:0] reg_wdata, reg_rdata;
    logic [14:0] nv_addr;
    int err_total = 0;
    int n_checks = 0;

    always #25 ref_clk = ~ref_clk;

    program_buffer_nv_store #(.WRITE_CYCLES(T), .SETUP_CYCLES(T), .WORD_CYCLES(T))
        u_program_buffer_nv_store (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .done_pulse(done_pulse), .resp(resp),
        .dl_valid(dl_valid), .dl(dl), .exec_addr(exec_addr), .exec_data(exec_data),
        .prog_len(prog_len), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_idx(reg_idx),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nv_rd(nv_rd), .nv_wr(nv_wr),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .busy(busy),
        .download_mode(download_mode), .nv_fault(nv_fault));

    nv_partner u_nv_partner (.ref_clk(ref_clk), .nv_rd(nv_rd), .nv_wr(nv_wr),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .reg_wr(reg_wr),
        .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic nv_store_pkg::cmd_req_t mk(input nv_store_pkg::cmd_t op,
        input logic [14:0] a, input logic [7:0] idx, input logic [3:0] cnt, input logic t2);
        mk = '{op: op, nv_addr: a, reg_idx: idx, reg_cnt: cnt, thread2: t2};
    endfunction

    // Fault also ends the wait: a failed load pulses done in the same cycle as the fault
    task automatic issue(input nv_store_pkg::cmd_req_t c);
        int k;
        logic quick;
        k = 0;
        // Clear, download, run and refused commands finish on the take edge
        quick = c.op inside {nv_store_pkg::clear_buffer_cmd, nv_store_pkg::enter_download_cmd,
            nv_store_pkg::run_buffer_cmd} || c.nv_addr >= nv_store_pkg::FACTORY_BASE ||
            (c.op inside {nv_store_pkg::multi_register_save_cmd,
            nv_store_pkg::multi_register_recall_cmd} && (c.reg_idx < 8'h0A ||
            c.reg_cnt == 4'h0 || c.reg_cnt > 4'hA || 9'(c.reg_idx) + 9'(c.reg_cnt) > 9'h0C8));
        while (cmd_ready !== 1'b1 && k < 50) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 50) begin
            err_total++;
            final_report();
        end
        @(posedge ref_clk);
        #1;
        cmd = c;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        // One-cycle answers already stand at the first falling edge
        @(negedge ref_clk);
        chk("busy", quick ? 0 : 1, busy);
        seen1 = resp.run_t1;
        seen2 = resp.run_t2;
        k = 0;
        while (done_pulse !== 1'b1 && nv_fault !== 1'b1 && k < 20000) begin
            @(negedge ref_clk);
            seen1 |= resp.run_t1;
            seen2 |= resp.run_t2;
            k++;
        end
        if (k >= 20000) begin
            err_total++;
            final_report();
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic prog_trip(input logic [14:0] a, input int n, input int ovh);
        issue(mk(nv_store_pkg::enter_download_cmd, 15'h0000, 8'h00, 4'h0, 1'b0));
        chk("download_mode", 1, download_mode);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            dl_valid = 1'b1;
            dl = '{addr: i[9:0], data: 16'hA000 + i[15:0]};
        end
        @(posedge ref_clk);
        #1;
        dl_valid = 1'b0;
        issue(mk(nv_store_pkg::store_buffer_cmd, a, 8'h00, 4'h0, 1'b0));
        chk("header length", n, u_nv_partner.mem[a][9:0]);
        if (ovh == 2) chk("null word", 0, u_nv_partner.mem[a + 1]);
        for (int i = 0; i < n; i++) begin
            chk("stored word", 16'hA000 + i, u_nv_partner.mem[a + ovh + i]);
        end
        issue(mk(nv_store_pkg::clear_buffer_cmd, 15'h0000, 8'h00, 4'h0, 1'b0));
        chk("cleared length", 0, prog_len);
        issue(mk(nv_store_pkg::load_buffer_cmd, a, 8'h00, 4'h0, 1'b0));
        chk("loaded length", n, prog_len);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            exec_addr = i[9:0];
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk("buffer word", 16'hA000 + i, exec_data);
        end
    endtask

    task automatic refusals();
        nv_store_pkg::cmd_req_t bad [5];
        bad[0] = mk(nv_store_pkg::multi_register_save_cmd, 15'h4000, 8'h09, 4'hA, 1'b0);
        bad[1] = mk(nv_store_pkg::multi_register_save_cmd, 15'h4000, 8'hBF, 4'hA, 1'b0);
        bad[2] = mk(nv_store_pkg::multi_register_recall_cmd, 15'h4000, 8'h0A, 4'h0, 1'b0);
        bad[3] = mk(nv_store_pkg::multi_register_save_cmd, 15'h4000, 8'h0A, 4'hB, 1'b0);
        bad[4] = mk(nv_store_pkg::store_buffer_cmd, 15'h7F00, 8'h00, 4'h0, 1'b0);
        foreach (bad[i]) begin
            issue(bad[i]);
            chk("refused", 1, resp.refused);
        end
        chk("untouched", 16'hFFFF, u_nv_partner.mem[15'h4000]);
    endtask

    task automatic multi_regs();
        for (int i = 0; i < 10; i++) begin
            u_nv_partner.regs[190 + i] = {16'h5A00 + i[15:0], 16'h3C00 + i[15:0]};
        end
        issue(mk(nv_store_pkg::multi_register_save_cmd, 15'h4000, 8'hBE, 4'hA, 1'b0));
        chk("accepted", 0, resp.refused);
        chk("null word", 0, u_nv_partner.mem[15'h4001]);
        for (int i = 0; i < 10; i++) begin
            chk("low half", 16'h3C00 + i, u_nv_partner.mem[15'h4002 + 2 * i]);
            chk("high half", 16'h5A00 + i, u_nv_partner.mem[15'h4003 + 2 * i]);
            u_nv_partner.regs[190 + i] = 32'h0000_0000;
        end
        chk("block end", 16'hFFFF, u_nv_partner.mem[15'h4016]);
        issue(mk(nv_store_pkg::multi_register_recall_cmd, 15'h4000, 8'hBE, 4'hA, 1'b0));
        for (int i = 0; i < 10; i++) begin
            chk("recalled", {16'h5A00 + i[15:0], 16'h3C00 + i[15:0]}, u_nv_partner.regs[190 + i]);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("ready after reset", 1, cmd_ready);
        prog_trip(15'h0200, 40, 2);
        prog_trip(15'h0300, 256, 3);
        issue(mk(nv_store_pkg::run_buffer_cmd, 15'h0000, 8'h00, 4'h0, 1'b0));
        chk("run thread one", 1, seen1);
        issue(mk(nv_store_pkg::load_and_execute_cmd, 15'h0300, 8'h00, 4'h0, 1'b0));
        chk("load and run", 1, seen1);
        issue(mk(nv_store_pkg::second_thread_launch_cmd, 15'h0200, 8'h00, 4'h0, 1'b1));
        chk("run thread two", 1, seen2);
        issue(mk(nv_store_pkg::first_thread_forced_load_cmd, 15'h0200, 8'h00, 4'h0, 1'b1));
        chk("forced load", 1, seen1);
        refusals();
        multi_regs();
        u_nv_partner.mem[15'h0205] = u_nv_partner.mem[15'h0205] ^ 16'h0001;
        issue(mk(nv_store_pkg::load_buffer_cmd, 15'h0200, 8'h00, 4'h0, 1'b0));
        chk("fault flag", 1, nv_fault);
        chk("error response", 1, resp.nv_error);
        chk("halted", 0, cmd_ready);
        @(posedge ref_clk);
        #1;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        chk("fault cleared", 0, nv_fault);
        chk("ready after fault reset", 1, cmd_ready);
        final_report();
    end
endmodule
